// File: core/crm_receiver.sv
// message receiver top: tone detector, deframer, actions and register slave
`timescale 1ns/1ps
`include "crm_map.svh"
module crm_receiver
  import crm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic line_tone,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic signature_power_extract_block_enable,
  output logic telephony_connected,
  output logic exch_adapter_bypass,
  output logic voice_adapter_startup,
  output logic voice_adapter_telephony
);
  crm_bit_if bit_bus ();

  logic [2:0] ctrl_q;
  logic [15:0] bitper_q;
  logic [3:0] repeat_q;
  logic [15:0] errcnt_q;
  logic [31:0] rdata_q;
  logic wait_q;
  logic signature_power_extract_block_q, tel_q, bypass_q, va_start_q, va_tel_q;
  logic up_pend_q, down_pend_q;
  logic [7:0] rx_trigger_identifier;
  logic [2:0] rx_lsu;
  logic rx_psb, rx_msg, rx_err;
  logic [3:0] rx_rep;

  // receive only: the line pin feeds the detector, nothing drives back
  crm_fsk_demod u_demod (
    .clk(clk),
    .rst(rst),
    .tone_in(line_tone),
    .bit_period(bitper_q),
    .bits(bit_bus.src)
  );

  crm_deframer u_deframer (
    .clk(clk),
    .rst(rst),
    .repeat_thr(repeat_q),
    .bits(bit_bus.snk),
    .msg_stb(rx_msg),
    .err_stb(rx_err),
    .trigger_identifier(rx_trigger_identifier),
    .last_startup_state(rx_lsu),
    .power_source_bit(rx_psb),
    .rep_cnt(rx_rep)
  );

  // trigger decode and addressing
  wire crm_kind_t kind_w = crm_decode(rx_trigger_identifier);
  wire role_va_w = ctrl_q[`CRM_CTRL_ROLE];
  wire [1:0] class_w = ctrl_q[`CRM_CTRL_CLASS_HI:`CRM_CTRL_CLASS_LO];
  wire class_hit_w = (kind_w == CRM_K_DISC_ANY) ||
    (kind_w == CRM_K_DISC1 && class_w == `CRM_CLASS_ONE) ||
    (kind_w == CRM_K_DISC2 && class_w == `CRM_CLASS_TWO) ||
    (kind_w == CRM_K_DISC3 && class_w == `CRM_CLASS_THREE);
  wire ru_disc_w = rx_msg && !role_va_w && class_hit_w;
  wire ru_reconn_w = rx_msg && !role_va_w && kind_w == CRM_K_RECONN;
  wire va_start_w = rx_msg && role_va_w && kind_w == CRM_K_VA_START;
  wire va_reconn_w = rx_msg && role_va_w && kind_w == CRM_K_VA_RECONN;

  // bus decode
  wire req_w = (avs_read || avs_write) && wait_q;
  wire wr_w = avs_write && !wait_q;
  wire sel_ctrl_w = avs_address == `CRM_REG_CTRL;
  wire sel_bitper_w = avs_address == `CRM_REG_BITPER;
  wire sel_repeat_w = avs_address == `CRM_REG_REPEAT;
  wire sel_status_w = avs_address == `CRM_REG_STATUS;
  wire sel_errcnt_w = avs_address == `CRM_REG_ERRCNT;
  wire [31:0] status_w = {4'h0, rx_rep, 4'h0, rx_trigger_identifier, rx_lsu, rx_psb,
    1'b0, bit_bus.carrier, va_tel_q, va_start_q, bypass_q, tel_q, signature_power_extract_block_q, up_pend_q};
  wire [31:0] rmux_w = sel_ctrl_w ? {29'h0, ctrl_q} :
    sel_bitper_w ? {16'h0, bitper_q} :
    sel_repeat_w ? {28'h0, repeat_q} :
    sel_status_w ? status_w :
    sel_errcnt_w ? {16'h0, errcnt_q} : 32'h0;

  // one idle cycle of waitrequest, then the answer
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end
    else
    begin
      wait_q <= !req_w;
      if (req_w && avs_read)
        rdata_q <= rmux_w;
    end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ctrl_q <= 3'h0;
      bitper_q <= `CRM_BITPER_RST;
      repeat_q <= `CRM_REPEAT_RST;
    end
    else if (wr_w)
    begin
      if (sel_ctrl_w)
        ctrl_q <= avs_writedata[2:0];
      if (sel_bitper_w)
        bitper_q <= avs_writedata[15:0];
      if (sel_repeat_w)
        repeat_q <= avs_writedata[3:0];
    end

  // counter clears on write; a same-cycle discard still counts
  always_ff @(posedge clk or posedge rst)
    if (rst)
      errcnt_q <= 16'h0;
    else if (rx_err)
      errcnt_q <= (wr_w && sel_errcnt_w) ? 16'h1 :
        ((errcnt_q == 16'hFFFF) ? errcnt_q : errcnt_q + 16'h1);
    else if (wr_w && sel_errcnt_w)
      errcnt_q <= 16'h0;

  // remote unit: break telephony first, engage extraction one cycle later
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      signature_power_extract_block_q <= 1'b0;
      tel_q <= 1'b1;
      bypass_q <= 1'b1;
      up_pend_q <= 1'b0;
      down_pend_q <= 1'b0;
    end
    else if (ru_disc_w)
    begin
      tel_q <= 1'b0;
      bypass_q <= 1'b0;
      up_pend_q <= 1'b1;
      down_pend_q <= 1'b0;
    end
    else if (ru_reconn_w)
    begin
      signature_power_extract_block_q <= 1'b0;
      bypass_q <= 1'b1;
      down_pend_q <= 1'b1;
      up_pend_q <= 1'b0;
    end
    else if (up_pend_q && !tel_q)
    begin
      signature_power_extract_block_q <= 1'b1;
      up_pend_q <= 1'b0;
    end
    else if (down_pend_q && !signature_power_extract_block_q)
    begin
      tel_q <= 1'b1;
      down_pend_q <= 1'b0;
    end

  // voice adapter commands
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      va_start_q <= 1'b0;
      va_tel_q <= 1'b0;
    end
    else
    begin
      if (va_start_w)
        va_start_q <= 1'b1;
      if (va_reconn_w)
        va_tel_q <= 1'b1;
    end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign signature_power_extract_block_enable = signature_power_extract_block_q;
  assign telephony_connected = tel_q;
  assign exch_adapter_bypass = bypass_q;
  assign voice_adapter_startup = va_start_q;
  assign voice_adapter_telephony = va_tel_q;

  // checks
  sequence seq_disc_taken;
    !tel_q && up_pend_q;
  endsequence

  sequence seq_pe_engaged;
    signature_power_extract_block_q && !tel_q && !up_pend_q;
  endsequence

  AST_DISC_ORDER: assert property (@(posedge clk) disable iff (rst)
    ru_disc_w |=> seq_disc_taken ##1 seq_pe_engaged)
    else $error("disconnect did not break telephony before extraction");

  AST_PE_NEEDS_NO_TEL: assert property (@(posedge clk) disable iff (rst)
    $rose(signature_power_extract_block_q) |-> !tel_q && !$past(tel_q))
    else $error("extraction engaged while telephony connected");

  AST_RECONN_ORDER: assert property (@(posedge clk) disable iff (rst)
    ru_reconn_w |=> !signature_power_extract_block_q && bypass_q ##1 tel_q)
    else $error("reconnect sequence wrong");

  AST_VA_START: assert property (@(posedge clk) disable iff (rst)
    va_start_w |=> va_start_q && $stable(signature_power_extract_block_q))
    else $error("adapter start-up not raised");

  AST_VALID_ONLY: assert property (@(posedge clk) disable iff (rst)
    rx_msg |-> crm_decode(rx_trigger_identifier) != CRM_K_NONE && crm_lsu_ok(rx_lsu) && !rx_err)
    else $error("invalid message accepted");

  AST_REPEAT: assert property (@(posedge clk) disable iff (rst)
    rx_msg |-> rx_rep == ((repeat_q == 4'h0) ? 4'h1 : repeat_q))
    else $error("accepted before repeat threshold");

  AST_DISCARD: assert property (@(posedge clk) disable iff (rst)
    rx_err |-> rx_rep == 4'h0 ##1 !rx_msg)
    else $error("discard left repeat count set");

  AST_BIT_PULSE: assert property (@(posedge clk) disable iff (rst)
    bit_bus.bit_stb |=> !bit_bus.bit_stb [*2])
    else $error("bit strobes too close");

  AST_BUS_ANSWER: assert property (@(posedge clk) disable iff (rst)
    (avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q)
    else $error("bus answer not one cycle");

  AST_DISC_NORMAL: assert property (@(posedge clk) disable iff (rst)
    ru_disc_w |=> !bypass_q && !tel_q)
    else $error("disconnect did not force normal mode");

  AST_CLASS_MISS: assert property (@(posedge clk) disable iff (rst)
    rx_msg && !role_va_w && !class_hit_w && kind_w != CRM_K_RECONN
    |=> $stable(tel_q) && $stable(signature_power_extract_block_q) && $stable(bypass_q))
    else $error("trigger for another class acted on");

  AST_ROLE_VA_KEEPS_RU: assert property (@(posedge clk) disable iff (rst)
    rx_msg && role_va_w |=> $stable(tel_q) && $stable(signature_power_extract_block_q) && $stable(bypass_q))
    else $error("remote unit outputs moved in adapter role");

  AST_ROLE_RU_KEEPS_VA: assert property (@(posedge clk) disable iff (rst)
    rx_msg && !role_va_w |=> $stable(va_start_q) && $stable(va_tel_q))
    else $error("adapter outputs moved in remote unit role");

  AST_VA_STICKY: assert property (@(posedge clk) disable iff (rst)
    va_start_q |=> va_start_q)
    else $error("adapter start-up dropped");

  AST_VA_TEL: assert property (@(posedge clk) disable iff (rst)
    va_reconn_w |=> va_tel_q)
    else $error("adapter reconnect not raised");

  AST_MSG_PULSE: assert property (@(posedge clk) disable iff (rst)
    rx_msg |=> !rx_msg)
    else $error("accept strobe longer than one cycle");

  AST_CARRIER_LOSS: assert property (@(posedge clk) disable iff (rst)
    !bit_bus.carrier |=> rx_rep == 4'h0)
    else $error("repeat chain kept over carrier loss");

  AST_ERR_COUNTS: assert property (@(posedge clk) disable iff (rst)
    rx_err && errcnt_q != 16'hFFFF |=> errcnt_q != 16'h0)
    else $error("discard not counted");

  AST_ERR_CLEAR: assert property (@(posedge clk) disable iff (rst)
    wr_w && sel_errcnt_w && !rx_err |=> errcnt_q == 16'h0)
    else $error("discard counter not cleared");

  AST_WR_BITPER: assert property (@(posedge clk) disable iff (rst)
    wr_w && sel_bitper_w |=> bitper_q == 16'($past(avs_writedata)))
    else $error("bit period write lost");

  AST_WR_CTRL: assert property (@(posedge clk) disable iff (rst)
    wr_w && sel_ctrl_w |=> ctrl_q == 3'($past(avs_writedata)))
    else $error("control write lost");

  AST_BUS_IDLE: assert property (@(posedge clk) disable iff (rst)
    !avs_read && !avs_write && wait_q |=> wait_q)
    else $error("answer without a request");

  AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (rst)
    !(req_w && avs_read) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
endmodule

// File: core/crm_map.svh
// constants for the copper reconfiguration message receiver
`ifndef CRM_MAP_SVH
`define CRM_MAP_SVH
`define CRM_CLK_HZ 10000000
`define CRM_MARK_HZ 1500
`define CRM_SPACE_HZ 2100
`define CRM_BAND_TOP_HZ 2600
`define CRM_BAND_SPLIT_HZ 1800
`define CRM_BAND_LOW_HZ 1200
`define CRM_FLAG 8'h7E
`define CRM_TRIGGER_IDENTIFIER_DISC1 8'h50
`define CRM_TRIGGER_IDENTIFIER_DISC2 8'hE8
`define CRM_TRIGGER_IDENTIFIER_DISC3 8'hB4
`define CRM_TRIGGER_IDENTIFIER_DISC_ANY 8'h0C
`define CRM_TRIGGER_IDENTIFIER_RECONN 8'h22
`define CRM_TRIGGER_IDENTIFIER_VA_START 8'h9A
`define CRM_TRIGGER_IDENTIFIER_VA_RECONN 8'hC6
`define CRM_LSU_OK 3'h0
`define CRM_LSU_OFFHOOK 3'h5
`define CRM_LSU_OTHER 3'h6
`define CRM_LSU_UNKNOWN 3'h3
`define CRM_TRIGGER_IDENTIFIER_LAST 4'h7
`define CRM_LSU_LAST 4'h2
`define CRM_REG_CTRL 5'h00
`define CRM_REG_BITPER 5'h04
`define CRM_REG_REPEAT 5'h08
`define CRM_REG_STATUS 5'h0C
`define CRM_REG_ERRCNT 5'h10
`define CRM_CTRL_ROLE 0
`define CRM_CTRL_CLASS_LO 1
`define CRM_CTRL_CLASS_HI 2
`define CRM_CLASS_ONE 2'h1
`define CRM_CLASS_TWO 2'h2
`define CRM_CLASS_THREE 2'h3
`define CRM_BITPER_RST 16'h208D
`define CRM_REPEAT_RST 4'h3
`endif

// File: core/crm_pkg.sv
// types and decode functions of the message receiver
package crm_pkg;
`include "crm_map.svh"
  typedef enum logic [2:0] {CRM_K_NONE, CRM_K_DISC1, CRM_K_DISC2, CRM_K_DISC3,
    CRM_K_DISC_ANY, CRM_K_RECONN, CRM_K_VA_START, CRM_K_VA_RECONN} crm_kind_t;
  typedef enum logic [1:0] {CRM_S_HUNT, CRM_S_TRIG, CRM_S_LSU, CRM_S_PSB} crm_state_t;

  function automatic crm_kind_t crm_decode(input logic [7:0] code);
    case (code)
      `CRM_TRIGGER_IDENTIFIER_DISC1: crm_decode = CRM_K_DISC1;
      `CRM_TRIGGER_IDENTIFIER_DISC2: crm_decode = CRM_K_DISC2;
      `CRM_TRIGGER_IDENTIFIER_DISC3: crm_decode = CRM_K_DISC3;
      `CRM_TRIGGER_IDENTIFIER_DISC_ANY: crm_decode = CRM_K_DISC_ANY;
      `CRM_TRIGGER_IDENTIFIER_RECONN: crm_decode = CRM_K_RECONN;
      `CRM_TRIGGER_IDENTIFIER_VA_START: crm_decode = CRM_K_VA_START;
      `CRM_TRIGGER_IDENTIFIER_VA_RECONN: crm_decode = CRM_K_VA_RECONN;
      default: crm_decode = CRM_K_NONE;
    endcase
  endfunction

  function automatic logic crm_lsu_ok(input logic [2:0] last_startup_state);
    crm_lsu_ok = (last_startup_state == `CRM_LSU_OK) || (last_startup_state == `CRM_LSU_OFFHOOK) ||
      (last_startup_state == `CRM_LSU_OTHER) || (last_startup_state == `CRM_LSU_UNKNOWN);
  endfunction
endpackage

// File: core/crm_bit_if.sv
// demodulated bit stream between the tone detector and the deframer
`timescale 1ns/1ps
interface crm_bit_if;
  logic bit_stb;
  logic bit_val;
  logic carrier;
  modport src (output bit_stb, output bit_val, output carrier);
  modport snk (input bit_stb, input bit_val, input carrier);
endinterface

// File: core/crm_fsk_demod.sv
// tone detector: half-period measurement and mid-bit sampling
`timescale 1ns/1ps
`include "crm_map.svh"
module crm_fsk_demod
  import crm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tone_in,
  input wire logic [15:0] bit_period,
  crm_bit_if.src bits
);
  localparam logic [15:0] MIN_H = 16'(`CRM_CLK_HZ / (2 * `CRM_BAND_TOP_HZ));
  localparam logic [15:0] SPLIT_H = 16'(`CRM_CLK_HZ / (2 * `CRM_BAND_SPLIT_HZ));
  localparam logic [15:0] MAX_H = 16'(`CRM_CLK_HZ / (2 * `CRM_BAND_LOW_HZ));
  logic s1_q, s2_q, s3_q, tone_q, carrier_q, stb_q, val_q;
  logic [15:0] half_q, phase_q;
  wire edge_w = s2_q ^ s3_q;
  // long half period is mark, short is space
  wire mark_w = (half_q >= SPLIT_H) && (half_q <= MAX_H);
  wire space_w = (half_q >= MIN_H) && (half_q < SPLIT_H);
  wire lost_w = half_q > MAX_H;
  wire resync_w = edge_w && (mark_w || space_w) && (!carrier_q || mark_w != tone_q);

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      {s1_q, s2_q, s3_q} <= 3'h0;
      half_q <= 16'h0;
    end
    else
    begin
      {s1_q, s2_q, s3_q} <= {tone_in, s1_q, s2_q};
      half_q <= edge_w ? 16'h1 : (lost_w ? half_q : half_q + 16'h1);
    end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      tone_q <= 1'b0;
      carrier_q <= 1'b0;
      stb_q <= 1'b0;
      val_q <= 1'b0;
      phase_q <= 16'h0;
    end
    else
    begin
      stb_q <= 1'b0;
      if (lost_w || (edge_w && !mark_w && !space_w))
        carrier_q <= 1'b0;
      else if (resync_w)
      begin
        carrier_q <= 1'b1;
        tone_q <= mark_w;
        phase_q <= bit_period >> 1;
      end
      else if (carrier_q && phase_q == 16'h0)
      begin
        stb_q <= 1'b1;
        val_q <= tone_q;
        phase_q <= bit_period - 16'h1;
      end
      else if (carrier_q)
        phase_q <= phase_q - 16'h1;
    end

  assign bits.bit_stb = stb_q;
  assign bits.bit_val = val_q;
  assign bits.carrier = carrier_q;
endmodule

// File: core/crm_deframer.sv
// flag hunt, field split, code check and repeat counting
`timescale 1ns/1ps
`include "crm_map.svh"
module crm_deframer
  import crm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] repeat_thr,
  crm_bit_if.snk bits,
  output logic msg_stb,
  output logic err_stb,
  output logic [7:0] trigger_identifier,
  output logic [2:0] last_startup_state,
  output logic power_source_bit,
  output logic [3:0] rep_cnt
);
  crm_state_t st_q;
  logic [7:0] sh_q, trigger_identifier_q;
  logic [2:0] lsu_q;
  logic [3:0] cnt_q, rep_q;
  logic [11:0] last_q;
  logic linked_q, msg_q, err_q;
  wire b = bits.bit_val;
  wire flag_w = {sh_q[6:0], b} == `CRM_FLAG;
  // exact code match only, so the code distances stay a pure detection margin
  wire code_ok_w = (crm_decode(trigger_identifier_q) != CRM_K_NONE) && crm_lsu_ok(lsu_q);
  wire chain_w = linked_q && (last_q == {trigger_identifier_q, lsu_q, b});
  wire [3:0] rep_nx_w = chain_w ? ((rep_q == 4'hF) ? rep_q : rep_q + 4'h1) : 4'h1;
  wire [3:0] thr_w = (repeat_thr == 4'h0) ? 4'h1 : repeat_thr;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      st_q <= CRM_S_HUNT;
      {sh_q, trigger_identifier_q, lsu_q, cnt_q, rep_q, last_q} <= 39'h0;
      {linked_q, msg_q, err_q} <= 3'h0;
    end
    else
    begin
      msg_q <= 1'b0;
      err_q <= 1'b0;
      if (!bits.carrier)
      begin
        st_q <= CRM_S_HUNT;
        linked_q <= 1'b0;
        rep_q <= 4'h0;
      end
      else if (bits.bit_stb)
      begin
        sh_q <= {sh_q[6:0], b};
        cnt_q <= cnt_q + 4'h1;
        case (st_q)
          CRM_S_HUNT:
            if (flag_w)
            begin
              st_q <= CRM_S_TRIG;
              cnt_q <= 4'h0;
              // anything but an immediate flag breaks the repeat chain
              if (cnt_q != `CRM_TRIGGER_IDENTIFIER_LAST)
                linked_q <= 1'b0;
            end
            else if (cnt_q == `CRM_TRIGGER_IDENTIFIER_LAST)
              linked_q <= 1'b0;
          CRM_S_TRIG:
          begin
            trigger_identifier_q <= {trigger_identifier_q[6:0], b};
            if (cnt_q == `CRM_TRIGGER_IDENTIFIER_LAST)
            begin
              st_q <= CRM_S_LSU;
              cnt_q <= 4'h0;
            end
          end
          CRM_S_LSU:
          begin
            lsu_q <= {lsu_q[1:0], b};
            if (cnt_q == `CRM_LSU_LAST)
              st_q <= CRM_S_PSB;
          end
          CRM_S_PSB:
          begin
            st_q <= CRM_S_HUNT;
            cnt_q <= 4'h0;
            if (code_ok_w)
            begin
              last_q <= {trigger_identifier_q, lsu_q, b};
              linked_q <= 1'b1;
              rep_q <= rep_nx_w;
              msg_q <= (rep_nx_w == thr_w);
            end
            else
            begin
              // no repair attempted: drop and hunt again
              linked_q <= 1'b0;
              rep_q <= 4'h0;
              err_q <= 1'b1;
            end
          end
          default: st_q <= CRM_S_HUNT;
        endcase
      end
    end

  assign msg_stb = msg_q;
  assign err_stb = err_q;
  assign trigger_identifier = last_q[11:4];
  assign last_startup_state = last_q[3:1];
  assign power_source_bit = last_q[0];
  assign rep_cnt = rep_q;
endmodule

// File: verif/crm_gen_model.sv
// far-side generator model: FSK message bursts onto the line
`timescale 1ns/1ps
`include "crm_map.svh"
module crm_gen_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [19:0] msg,
  input wire logic [3:0] copies,
  output logic line_tone,
  output logic busy
);
  localparam int HALF_MARK = `CRM_CLK_HZ / (2 * `CRM_MARK_HZ);
  localparam int HALF_SPACE = `CRM_CLK_HZ / (2 * `CRM_SPACE_HZ);
  // whole half-cycles per bit: 3 mark or 4 space, close to one bit period of 9760
  logic [19:0] msg_q;
  logic [4:0] idx_q;
  logic [2:0] left_q;
  logic [15:0] cnt_q;
  logic [3:0] rep_q;
  wire logic cur_bit = msg_q[5'd19 - idx_q];
  wire logic [15:0] cur_len = cur_bit ? 16'(HALF_MARK) : 16'(HALF_SPACE);
  wire logic last_bit = (idx_q == 5'd19);
  wire logic [4:0] nidx = last_bit ? 5'd0 : idx_q + 5'd1;
  wire logic nbit = msg_q[5'd19 - nidx];
  wire logic [2:0] nhalves = nbit ? 3'd3 : 3'd4;
  wire logic [15:0] nlen = nbit ? 16'(HALF_MARK) : 16'(HALF_SPACE);
  // one-way sender: nothing is read back from the line
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      line_tone <= 1'b0;
      msg_q <= 20'h0;
      idx_q <= 5'h0;
      left_q <= 3'h0;
      cnt_q <= 16'h0;
      rep_q <= 4'h0;
    end
    else if (!busy && start)
    begin
      busy <= 1'b1;
      line_tone <= ~line_tone;
      msg_q <= msg;
      idx_q <= 5'h0;
      rep_q <= copies;
      left_q <= msg[19] ? 3'd3 : 3'd4;
      cnt_q <= msg[19] ? 16'(HALF_MARK) : 16'(HALF_SPACE);
    end
    else if (busy && cnt_q == 16'h1)
    begin
      line_tone <= ~line_tone;
      if (left_q != 3'h1)
      begin
        left_q <= left_q - 3'h1;
        cnt_q <= cur_len;
      end
      else if (last_bit && rep_q <= 4'h1)
        busy <= 1'b0;
      else
      begin
        // next copy starts on the very next bit, no gap
        idx_q <= nidx;
        rep_q <= last_bit ? rep_q - 4'h1 : rep_q;
        left_q <= nhalves;
        cnt_q <= nlen;
      end
    end
    else if (busy)
      cnt_q <= cnt_q - 16'h1;
  end
endmodule

// File: verif/testbench.sv
// bench: register accesses, generator bursts and expected outcomes
`timescale 1ns/1ps
`include "crm_map.svh"
module testbench;
  localparam logic [15:0] BITPER = 16'h2620;
  logic clk;
  logic rst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  wire logic [4:0] outs;
  logic line_tone;
  logic gen_start;
  logic gen_busy;
  logic [19:0] gen_msg;
  logic [3:0] gen_copies;
  logic [31:0] rd;
  int miscompares;
  int samples_checked;

  crm_receiver i_dut (.clk(clk), .rst(rst), .line_tone(line_tone), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .signature_power_extract_block_enable(outs[4]), .telephony_connected(outs[3]), .exch_adapter_bypass(outs[2]),
    .voice_adapter_startup(outs[1]), .voice_adapter_telephony(outs[0]));
  crm_gen_model i_gen (.clk(clk), .rst(rst), .start(gen_start), .msg(gen_msg),
    .copies(gen_copies), .line_tone(line_tone), .busy(gen_busy));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      miscompares++;
      finish_test();
    end
  endtask

  task automatic rdchk(input string what, input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic send(input logic [7:0] trig, input logic [2:0] last_startup_state, input logic power_source_bit,
      input logic [3:0] n);
    int t;
    t = 0;
    @(posedge clk);
    gen_msg <= {`CRM_FLAG, trig, last_startup_state, power_source_bit};
    gen_copies <= n;
    gen_start <= 1'b1;
    repeat (2) @(posedge clk);
    gen_start <= 1'b0;
    while (gen_busy === 1'b1 && t < 1000000)
    begin
      @(posedge clk);
      t++;
    end
    if (gen_busy !== 1'b0)
    begin
      miscompares++;
      finish_test();
    end
    // idle past the carrier-loss limit so each burst stands alone
    repeat (6000) @(posedge clk);
  endtask

  initial
  begin
    rst = 1'b1;
    avs_address = 5'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    gen_start = 1'b0;
    gen_msg = 20'h0;
    gen_copies = 4'h0;
    miscompares = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset outputs", 32'h0C, {27'h0, outs});
    rdchk("ctrl", `CRM_REG_CTRL, 32'h0);
    rdchk("bitper", `CRM_REG_BITPER, {16'h0, `CRM_BITPER_RST});
    rdchk("repeat", `CRM_REG_REPEAT, {28'h0, `CRM_REPEAT_RST});
    rdchk("errcnt", `CRM_REG_ERRCNT, 32'h0);
    bus(1'b1, 5'h14, 32'hFFFF_FFFF);
    rdchk("unmapped", 5'h14, 32'h0);
    bus(1'b1, `CRM_REG_BITPER, {16'h0, BITPER});
    bus(1'b1, `CRM_REG_REPEAT, 32'h2);
    bus(1'b1, `CRM_REG_CTRL, {29'h0, `CRM_CLASS_ONE, 1'b0});
    rdchk("ctrl", `CRM_REG_CTRL, 32'h2);
    send(`CRM_TRIGGER_IDENTIFIER_DISC1, `CRM_LSU_OFFHOOK, 1'b1, 4'h1);
    chk("one copy", 32'h0C, {27'h0, outs});
    send(`CRM_TRIGGER_IDENTIFIER_DISC1, `CRM_LSU_OFFHOOK, 1'b1, 4'h2);
    chk("disconnect", 32'h10, {27'h0, outs});
    bus(1'b0, `CRM_REG_STATUS, 32'h0);
    chk("status fields", 32'h50B, {20'h0, rd[19:8]});
    // zero threshold behaves as a single copy
    bus(1'b1, `CRM_REG_REPEAT, 32'h0);
    send(8'h51, `CRM_LSU_OK, 1'b0, 4'h1);
    send(`CRM_TRIGGER_IDENTIFIER_RECONN, 3'h1, 1'b0, 4'h1);
    chk("after bad codes", 32'h10, {27'h0, outs});
    rdchk("errcnt", `CRM_REG_ERRCNT, 32'h2);
    bus(1'b1, `CRM_REG_ERRCNT, 32'h0);
    rdchk("errcnt clear", `CRM_REG_ERRCNT, 32'h0);
    send(`CRM_TRIGGER_IDENTIFIER_RECONN, `CRM_LSU_OK, 1'b0, 4'h1);
    chk("reconnect", 32'h0C, {27'h0, outs});
    send(`CRM_TRIGGER_IDENTIFIER_DISC2, `CRM_LSU_OTHER, 1'b0, 4'h1);
    chk("other class", 32'h0C, {27'h0, outs});
    send(`CRM_TRIGGER_IDENTIFIER_DISC_ANY, `CRM_LSU_UNKNOWN, 1'b1, 4'h1);
    chk("any class", 32'h10, {27'h0, outs});
    bus(1'b1, `CRM_REG_CTRL, 32'h1);
    send(`CRM_TRIGGER_IDENTIFIER_VA_START, `CRM_LSU_OK, 1'b0, 4'h1);
    chk("adapter start", 32'h12, {27'h0, outs});
    send(`CRM_TRIGGER_IDENTIFIER_VA_RECONN, `CRM_LSU_OK, 1'b0, 4'h1);
    chk("adapter reconnect", 32'h13, {27'h0, outs});
    bus(1'b1, `CRM_REG_CTRL, {29'h0, `CRM_CLASS_THREE, 1'b1});
    send(`CRM_TRIGGER_IDENTIFIER_DISC3, `CRM_LSU_OK, 1'b0, 4'h1);
    chk("disconnect in adapter role", 32'h13, {27'h0, outs});
    bus(1'b0, `CRM_REG_STATUS, 32'h0);
    chk("last trigger", {24'h0, `CRM_TRIGGER_IDENTIFIER_DISC3}, {24'h0, rd[19:12]});
    finish_test();
  end
endmodule
